// *** rtl/vssc_pkg.sv ***
// Purpose: Shared constants and carriers for the setpoint and sync control block
// Assumes: 100 MHz main clock; PMBus framing is decoded outside into word commands
// Notes: Setpoint and scale codes carry a 9-bit binary fraction
package vssc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CLK_PERIOD_NS = 10;

    localparam logic [7:0] CODE_SETPOINT = 8'h21;
    localparam logic [7:0] CODE_LOOP_SCALE = 8'h29;
    localparam logic [7:0] CODE_STORE_ALL = 8'h11;
    localparam logic [7:0] CODE_SYNC_STATUS = 8'hD0;

    localparam logic [15:0] SETPOINT_RESET = 16'h0100;
    localparam logic [15:0] SCALE_ONE = 16'h0200;
    localparam logic [15:0] SCALE_HALF = 16'h0100;
    localparam int SCALE_FRAC_BITS = 9;
    localparam logic [15:0] DAC_CODE_MIN = 16'h00B3;
    localparam logic [15:0] DAC_CODE_MAX = 16'h034D;

    localparam int STAT_LOCKED_BIT = 0;
    localparam int STAT_EXT_RATE_BIT = 1;
    localparam int STAT_SLAVE_BIT = 2;
    localparam int STAT_RANGE_BIT = 3;

    localparam int FSW_DEFAULT_KHZ = 500;
    localparam int FSW_MIN_KHZ = 300;
    localparam int FSW_MAX_KHZ = 1000;
    localparam int SYNC_TOL_PCT = 20;
    localparam int LOSS_PERIODS = 2;
    localparam int SYNC_LAG_NS = 500;
    localparam int SYNC_PIPE_CYC = 3;
    localparam int SYNC_LAG_CYC =
        (SYNC_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - SYNC_PIPE_CYC;
    localparam int PERIOD_W = 16;

    typedef enum logic [1:0] {
        VSSC_FREE,
        VSSC_ACQUIRE,
        VSSC_LOCKED
    } vssc_sync_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } vssc_cmd_req_t;

    typedef struct packed {
        logic ack;
        logic nak;
        logic [15:0] rdata;
    } vssc_cmd_rsp_t;

    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] scale;
    } vssc_nvm_image_t;
endpackage : vssc_pkg

// *** rtl/vssc_top.sv ***
// Purpose: Output setpoint registers, reference code and switching clock source control
// Assumes: Commands arrive decoded on CLK; SYNC_CLK is the external sync pin used as a clock
// Notes: The non-volatile copy lives outside; it is read after reset and written on store
// Function
// - Host writes setpoint word at 21h
// - Output depends on setpoint, scale, range resistor
// - Shipped defaults: scale one, setpoint 100h
// - Written setpoint held until rewritten
// - Power-up reloads setpoint from non-volatile copy
// - Store-all copies setpoint into non-volatile memory
// - Reference spans 350 to 1650 mV
// - Select pin grounded gives 500 kHz default
// - Free-running rate kept within 300 kHz-1 MHz
// - Sync pin is input; free-run without clock
// - Lock to leading edge, 500 ns lag
// - Late-arriving sync clock is still acquired
// - Lost sync falls back to free-running rate
// - Master locks rising, slave locks falling edge
module vssc_top #(
    parameter int LAG_CYC = vssc_pkg::SYNC_LAG_CYC
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SYNC_CLK,
    input wire vssc_pkg::vssc_cmd_req_t CMD_REQ,
    output vssc_pkg::vssc_cmd_rsp_t CMD_RSP,
    input wire vssc_pkg::vssc_nvm_image_t NVM_IMAGE,
    output logic NVM_STORE,
    output vssc_pkg::vssc_nvm_image_t NVM_WIMAGE,
    input wire logic FREQ_SOURCE_SELECT,
    input wire logic [9:0] FREQ_SET_RESISTOR_PIN,
    input wire logic RANGE_RESISTOR,
    input wire logic PARALLEL_SLAVE,
    output logic [9:0] REF_DAC_CODE,
    output logic [15:0] VOUT_CODE,
    output logic SWITCH_NODE,
    output logic SYNC_LOCKED
);
    import vssc_pkg::*;

    localparam int lag_chk = LAG_CYC + 1;

    function automatic logic [PERIOD_W-1:0] period_of(input int khz);
        int k;
        k = khz;
        if (k < FSW_MIN_KHZ) begin
            k = FSW_MIN_KHZ;
        end
        if (k > FSW_MAX_KHZ) begin
            k = FSW_MAX_KHZ;
        end
        return PERIOD_W'((CLK_MHZ * 1000) / k);
    endfunction : period_of

    function automatic logic in_window(input logic [PERIOD_W-1:0] gap,
                                       input logic [PERIOD_W-1:0] per);
        int g;
        int p;
        g = int'(gap) * 100;
        p = int'(per);
        return (g >= p * (100 - SYNC_TOL_PCT)) && (g <= p * (100 + SYNC_TOL_PCT));
    endfunction : in_window

    // Registers and NVM copy
    logic [15:0] setpoint_ff;
    logic [15:0] scale_ff;
    logic restore_ff;
    vssc_cmd_rsp_t rsp_ff;
    logic store_ff;
    vssc_nvm_image_t wimage_ff;
    logic [15:0] status;

    // Pin synchronisers
    logic fsel_s1_ff, fsel_s2_ff;
    logic [9:0] rt_s1_ff, rt_s2_ff;
    logic range_s1_ff, range_s2_ff;
    logic slave_s1_ff, slave_s2_ff;

    // Sync clock domain and crossing
    logic rise_tgl_ff, fall_tgl_ff;
    logic rise_s1_ff, rise_s2_ff, rise_s3_ff;
    logic fall_s1_ff, fall_s2_ff, fall_s3_ff;
    logic sync_edge;
    logic sync_take;

    vssc_sync_state_t state_ff;
    logic [PERIOD_W-1:0] period_ff;
    logic [PERIOD_W-1:0] gap_ff;
    logic [PERIOD_W-1:0] phase_ff;
    logic [PERIOD_W-1:0] nxt_phase;
    logic [PERIOD_W-1:0] wrap_at;
    logic [7:0] lag_ff;
    logic sw_ff;
    logic [9:0] dac_ff;
    logic [15:0] vout_ff;
    logic [31:0] scaled;
    logic [15:0] ref_raw;

    assign status = {12'h000, range_s2_ff, slave_s2_ff, fsel_s2_ff, state_ff == VSSC_LOCKED};

    // Restore pulls the stored copy in at the first edge after release
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            restore_ff <= 1'b1;
        end else begin
            restore_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            setpoint_ff <= SETPOINT_RESET;
            scale_ff <= SCALE_ONE;
        end else if (restore_ff) begin
            setpoint_ff <= NVM_IMAGE.setpoint;
            scale_ff <= NVM_IMAGE.scale;
        end else if (CMD_REQ.valid && CMD_REQ.write) begin
            if (CMD_REQ.code == CODE_SETPOINT) begin
                setpoint_ff <= CMD_REQ.wdata;
            end
            if (CMD_REQ.code == CODE_LOOP_SCALE) begin
                scale_ff <= CMD_REQ.wdata;
            end
        end
    end

    // One answer per command, one cycle later; status is read-only
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.ack <= 1'b0;
            rsp_ff.nak <= 1'b0;
            if (CMD_REQ.valid && !restore_ff) begin
                case (CMD_REQ.code)
                    CODE_SETPOINT: begin
                        rsp_ff.ack <= 1'b1;
                        rsp_ff.rdata <= CMD_REQ.write ? rsp_ff.rdata : setpoint_ff;
                    end
                    CODE_LOOP_SCALE: begin
                        rsp_ff.ack <= 1'b1;
                        rsp_ff.rdata <= CMD_REQ.write ? rsp_ff.rdata : scale_ff;
                    end
                    CODE_STORE_ALL: begin
                        rsp_ff.ack <= CMD_REQ.write;
                        rsp_ff.nak <= !CMD_REQ.write;
                    end
                    CODE_SYNC_STATUS: begin
                        rsp_ff.ack <= !CMD_REQ.write;
                        rsp_ff.nak <= CMD_REQ.write;
                        rsp_ff.rdata <= CMD_REQ.write ? rsp_ff.rdata : status;
                    end
                    default: begin
                        rsp_ff.nak <= 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            store_ff <= 1'b0;
            wimage_ff <= '0;
        end else begin
            store_ff <= 1'b0;
            if (CMD_REQ.valid && CMD_REQ.write && !restore_ff && CMD_REQ.code == CODE_STORE_ALL) begin
                store_ff <= 1'b1;
                wimage_ff <= '{setpoint: setpoint_ff, scale: scale_ff};
            end
        end
    end

    // Straps are slow pins; two flops each before any logic sees them
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            fsel_s1_ff <= 1'b0;
            fsel_s2_ff <= 1'b0;
            rt_s1_ff <= '0;
            rt_s2_ff <= '0;
            range_s1_ff <= 1'b0;
            range_s2_ff <= 1'b0;
            slave_s1_ff <= 1'b0;
            slave_s2_ff <= 1'b0;
        end else begin
            fsel_s1_ff <= FREQ_SOURCE_SELECT;
            fsel_s2_ff <= fsel_s1_ff;
            rt_s1_ff <= FREQ_SET_RESISTOR_PIN;
            rt_s2_ff <= rt_s1_ff;
            range_s1_ff <= RANGE_RESISTOR;
            range_s2_ff <= range_s1_ff;
            slave_s1_ff <= PARALLEL_SLAVE;
            slave_s2_ff <= slave_s1_ff;
        end
    end

    // Reference code: setpoint times loop scale, held inside the converter span
    assign scaled = 32'(setpoint_ff) * 32'(scale_ff);
    assign ref_raw = scaled[SCALE_FRAC_BITS +: 16];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            dac_ff <= SETPOINT_RESET[9:0];
            vout_ff <= SETPOINT_RESET;
        end else begin
            if (ref_raw < DAC_CODE_MIN) begin
                dac_ff <= DAC_CODE_MIN[9:0];
            end else if (ref_raw > DAC_CODE_MAX) begin
                dac_ff <= DAC_CODE_MAX[9:0];
            end else begin
                dac_ff <= ref_raw[9:0];
            end
            // Range resistor doubles the divider so the half scale is undone at the output
            vout_ff <= (range_s2_ff && scale_ff == SCALE_HALF) ? setpoint_ff : ref_raw;
        end
    end

    // Sync pin as a clock: only toggles live here, so a stopped clock strands nothing
    always_ff @(posedge SYNC_CLK or posedge RESET) begin
        if (RESET) begin
            rise_tgl_ff <= 1'b0;
        end else begin
            rise_tgl_ff <= !rise_tgl_ff;
        end
    end

    always_ff @(negedge SYNC_CLK or posedge RESET) begin
        if (RESET) begin
            fall_tgl_ff <= 1'b0;
        end else begin
            fall_tgl_ff <= !fall_tgl_ff;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rise_s1_ff <= 1'b0;
            rise_s2_ff <= 1'b0;
            rise_s3_ff <= 1'b0;
            fall_s1_ff <= 1'b0;
            fall_s2_ff <= 1'b0;
            fall_s3_ff <= 1'b0;
        end else begin
            rise_s1_ff <= rise_tgl_ff;
            rise_s2_ff <= rise_s1_ff;
            rise_s3_ff <= rise_s2_ff;
            fall_s1_ff <= fall_tgl_ff;
            fall_s2_ff <= fall_s1_ff;
            fall_s3_ff <= fall_s2_ff;
        end
    end

    assign sync_edge = slave_s2_ff ? (fall_s2_ff ^ fall_s3_ff) : (rise_s2_ff ^ rise_s3_ff);
    assign sync_take = sync_edge && state_ff != VSSC_FREE && in_window(gap_ff, period_ff);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            period_ff <= period_of(FSW_DEFAULT_KHZ);
        end else if (fsel_s2_ff) begin
            period_ff <= period_of(int'(rt_s2_ff));
        end else begin
            period_ff <= period_of(FSW_DEFAULT_KHZ);
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            gap_ff <= '0;
        end else if (sync_edge) begin
            gap_ff <= '0;
        end else if (gap_ff != {PERIOD_W{1'b1}}) begin
            gap_ff <= gap_ff + 1'b1;
        end
    end

    // Free until an edge, acquire measures one interval, locked needs each edge in window
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_ff <= VSSC_FREE;
        end else if (state_ff != VSSC_FREE
                     && 32'(gap_ff) >= 32'(LOSS_PERIODS) * 32'(period_ff)) begin
            state_ff <= VSSC_FREE;
        end else begin
            case (state_ff)
                VSSC_FREE: begin
                    if (sync_edge) begin
                        state_ff <= VSSC_ACQUIRE;
                    end
                end
                VSSC_ACQUIRE: begin
                    if (sync_take) begin
                        state_ff <= VSSC_LOCKED;
                    end
                end
                VSSC_LOCKED: begin
                    if (sync_edge && !sync_take) begin
                        state_ff <= VSSC_ACQUIRE;
                    end
                end
                default: begin
                    state_ff <= VSSC_FREE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            lag_ff <= '0;
        end else if (sync_take) begin
            lag_ff <= 8'(LAG_CYC);
        end else if (lag_ff != '0) begin
            lag_ff <= lag_ff - 1'b1;
        end
    end

    // Locked edges restart the count, so a sync slower than the free rate cannot wrap early
    assign wrap_at = (state_ff == VSSC_LOCKED) ? period_ff + (period_ff >> 1) : period_ff - 1'b1;
    // The phase counter never stops, so losing sync leaves no hole in switching
    always_comb begin
        if (lag_ff == 8'h01) begin
            nxt_phase = '0;
        end else if (phase_ff >= wrap_at) begin
            nxt_phase = '0;
        end else begin
            nxt_phase = phase_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            phase_ff <= '0;
            sw_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            sw_ff <= nxt_phase < (period_ff >> 1);
        end
    end

    assign CMD_RSP = rsp_ff;
    assign NVM_STORE = store_ff;
    assign NVM_WIMAGE = wimage_ff;
    assign REF_DAC_CODE = dac_ff;
    assign VOUT_CODE = vout_ff;
    assign SWITCH_NODE = sw_ff;
    assign SYNC_LOCKED = state_ff == VSSC_LOCKED;

    a_setpoint_write: assert property (@(posedge CLK) disable iff (RESET)
        CMD_REQ.valid && CMD_REQ.write && CMD_REQ.code == CODE_SETPOINT && !restore_ff
        |=> setpoint_ff == $past(CMD_REQ.wdata) ##1 REF_DAC_CODE >= DAC_CODE_MIN[9:0])
        else $error("setpoint write not taken");
    a_setpoint_holds: assert property (@(posedge CLK) disable iff (RESET)
        !(CMD_REQ.valid && CMD_REQ.write) && !restore_ff |=> $stable(setpoint_ff))
        else $error("setpoint changed without a write");
    a_restore_nvm: assert property (@(posedge CLK) disable iff (RESET)
        restore_ff |=> setpoint_ff == $past(NVM_IMAGE.setpoint) && !restore_ff)
        else $error("stored setpoint not restored");
    a_store_copies: assert property (@(posedge CLK) disable iff (RESET)
        CMD_REQ.valid && CMD_REQ.write && CMD_REQ.code == CODE_STORE_ALL && !restore_ff
        |=> NVM_STORE && NVM_WIMAGE.setpoint == $past(setpoint_ff) ##1 !NVM_STORE)
        else $error("store did not copy setpoint");
    a_dac_span: assert property (@(posedge CLK) disable iff (RESET)
        REF_DAC_CODE >= DAC_CODE_MIN[9:0] && REF_DAC_CODE <= DAC_CODE_MAX[9:0])
        else $error("reference code out of span");
    a_dac_scale: assert property (@(posedge CLK) disable iff (RESET)
        scale_ff == SCALE_ONE && setpoint_ff >= DAC_CODE_MIN && setpoint_ff <= DAC_CODE_MAX
        && $stable(setpoint_ff) && $stable(scale_ff) |=> REF_DAC_CODE == $past(setpoint_ff[9:0]))
        else $error("reference does not follow setpoint");
    a_default_rate: assert property (@(posedge CLK) disable iff (RESET)
        !fsel_s2_ff |=> period_ff == period_of(FSW_DEFAULT_KHZ))
        else $error("default rate not used");
    a_rate_span: assert property (@(posedge CLK) disable iff (RESET)
        period_ff >= period_of(FSW_MAX_KHZ) && period_ff <= period_of(FSW_MIN_KHZ))
        else $error("switching period out of span");
    a_lock_lag: assert property (@(posedge CLK) disable iff (RESET)
        sync_take |-> ##[lag_chk:lag_chk] (phase_ff == '0 && SWITCH_NODE))
        else $error("switch edge not at sync lag");
    a_loss_fallback: assert property (@(posedge CLK) disable iff (RESET)
        state_ff != VSSC_FREE && !sync_edge && 32'(gap_ff) >= 32'(LOSS_PERIODS) * 32'(period_ff)
        |=> state_ff == VSSC_FREE && phase_ff == $past(nxt_phase))
        else $error("sync loss not handled");
    a_slave_edge: assert property (@(posedge CLK) disable iff (RESET)
        slave_s2_ff && (rise_s2_ff ^ rise_s3_ff) && !(fall_s2_ff ^ fall_s3_ff) |-> !sync_edge)
        else $error("slave used the rising edge");

    c_lock: cover property (@(posedge CLK) disable iff (RESET)
        state_ff == VSSC_ACQUIRE ##1 state_ff == VSSC_LOCKED);
    c_loss: cover property (@(posedge CLK) disable iff (RESET)
        state_ff == VSSC_LOCKED ##1 state_ff == VSSC_FREE);
    c_store: cover property (@(posedge CLK) disable iff (RESET) NVM_STORE);
    c_slave_lock: cover property (@(posedge CLK) disable iff (RESET)
        slave_s2_ff && state_ff == VSSC_LOCKED);
endmodule : vssc_top

// *** testbench/vssc_far_model.sv ***
// Purpose: Far-side model: external sync clock source and non-volatile setpoint copy
// Assumes: Rate and start time of the sync clock are set by the bench
// Notes: Sync rests low while stopped, so no stray edge reaches the lock logic
module vssc_far_model #(
    parameter vssc_pkg::vssc_nvm_image_t INIT_IMAGE = {16'h0180, 16'h0200}
) (
    input wire logic clk,
    input wire logic nvm_store,
    input wire vssc_pkg::vssc_nvm_image_t nvm_wimage,
    output vssc_pkg::vssc_nvm_image_t nvm_image,
    input wire logic sync_run,
    input wire logic [15:0] sync_half_ns,
    output logic sync_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    import vssc_pkg::*;

    // Not cleared by reset, as real non-volatile storage survives it
    initial nvm_image = INIT_IMAGE;
    always @(posedge clk) begin
        if (nvm_store) begin
            nvm_image <= nvm_wimage;
        end
    end

    // Equal halves keep 50% duty; one source may feed both paired devices
    // Whole pulses only: a stop lets the current pulse finish low, so no runt edge appears
    initial sync_clk = 1'b0;
    always begin
        @(posedge sync_run);
        while (sync_run) begin
            #(sync_half_ns) sync_clk = 1'b1;
            #(sync_half_ns) sync_clk = 1'b0;
        end
    end
endmodule : vssc_far_model

// *** testbench/vout_setpoint_and_sync_control_tb_top.sv ***
// Purpose: Self-checking bench for setpoint, reference code and sync control
// Assumes: Commands arrive decoded, one at a time, 1 ns after the rising edge
// Notes: Sync periods are kept near the free rate so lock is reachable in a short run
module vout_setpoint_and_sync_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import vssc_pkg::*;

    logic clk;
    logic rst;
    logic sync_clk;
    logic sync_run;
    logic sel;
    logic range_r;
    logic slave;
    logic [9:0] rkhz;
    logic [15:0] half_ns;
    vssc_cmd_req_t req;
    vssc_cmd_rsp_t rsp;
    vssc_nvm_image_t nvm_img;
    vssc_nvm_image_t nvm_w;
    logic nvm_st;
    logic st_seen;
    logic sw;
    logic locked;
    logic [9:0] ref_code;
    logic [15:0] vout;
    int err_count;
    int compares;
    int cyc;
    int n;
    int i;
    int lag;
    realtime t0;
    logic [15:0] sp_tab [4] = '{16'h0200, 16'h00B3, 16'h034D, 16'h0166};

    vssc_top u_dut (
        .CLK(clk), .RESET(rst), .SYNC_CLK(sync_clk), .CMD_REQ(req), .CMD_RSP(rsp),
        .NVM_IMAGE(nvm_img), .NVM_STORE(nvm_st), .NVM_WIMAGE(nvm_w),
        .FREQ_SOURCE_SELECT(sel), .FREQ_SET_RESISTOR_PIN(rkhz), .RANGE_RESISTOR(range_r),
        .PARALLEL_SLAVE(slave), .REF_DAC_CODE(ref_code), .VOUT_CODE(vout),
        .SWITCH_NODE(sw), .SYNC_LOCKED(locked)
    );

    vssc_far_model u_far (
        .clk(clk), .nvm_store(nvm_st), .nvm_wimage(nvm_w), .nvm_image(nvm_img),
        .sync_run(sync_run), .sync_half_ns(half_ns), .sync_clk(sync_clk)
    );

    always #5 clk = ~clk;

    task automatic finish_test;
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Ceiling well above the longest path through the sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    function automatic logic [9:0] exp_ref(input logic [15:0] sp, input logic [15:0] sc);
        logic [31:0] t;
        t = (32'(sp) * 32'(sc)) >> SCALE_FRAC_BITS;
        if (t < 32'(DAC_CODE_MIN)) begin
            t = 32'(DAC_CODE_MIN);
        end
        if (t > 32'(DAC_CODE_MAX)) begin
            t = 32'(DAC_CODE_MAX);
        end
        return t[9:0];
    endfunction : exp_ref

    task automatic do_reset;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        chk(vout, 16'h0100);
        chk(ref_code, 10'h100);
        rst = 1'b0;
        tick(3);
    endtask : do_reset

    // ea is {ack, nak}; the answer stands one cycle, so it is looked at right after the taking edge
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                       input logic [1:0] ea, input logic [15:0] er);
        req = '{valid: 1'b1, write: w, code: c, wdata: d};
        tick(1);
        req.valid = 1'b0;
        st_seen = nvm_st;
        chk({rsp.ack, rsp.nak}, ea);
        if (!w && ea == 2'b10) begin
            chk(rsp.rdata, er);
        end
        tick(1);
    endtask : cmd

    task automatic wait_rise;
        logic p;
        n = 0;
        do begin
            p = sw;
            @(posedge clk);
            #1;
            n++;
        end while (!(p === 1'b0 && sw === 1'b1) && n < 800);
    endtask : wait_rise

    // First interval after a rate change may be mixed, so the third is measured
    task automatic chk_per(input int exp);
        tick(4);
        wait_rise();
        wait_rise();
        wait_rise();
        chk(n, exp);
    endtask : chk_per

    task automatic wait_lock(input logic want);
        n = 0;
        while (locked !== want && n < 1000) begin
            tick(1);
            n++;
        end
        chk(locked, want);
    endtask : wait_lock

    task automatic chk_lag;
        wait_rise();
        lag = int'($realtime - t0);
        chk(lag >= 481 && lag <= 541, 1'b1);
    endtask : chk_lag

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sync_run = 1'b0;
        sel = 1'b0;
        range_r = 1'b0;
        slave = 1'b0;
        rkhz = 10'd500;
        half_ns = 16'd1100;
        req = '0;
        err_count = 0;
        compares = 0;
        cyc = 0;
        do_reset();
        cmd(1'b0, CODE_SETPOINT, 16'h0000, 2'b10, 16'h0180);
        chk(ref_code, 10'h180);
        cmd(1'b0, CODE_SYNC_STATUS, 16'h0000, 2'b10, 16'h0000);
        for (i = 0; i < 4; i++) begin
            cmd(1'b1, CODE_SETPOINT, sp_tab[i], 2'b10, 16'h0000);
            cmd(1'b0, CODE_SETPOINT, 16'h0000, 2'b10, sp_tab[i]);
            chk(ref_code, exp_ref(sp_tab[i], SCALE_ONE));
            chk(vout, sp_tab[i]);
        end
        // Range resistor goes in before the half scale so the setpoint stays in its window
        range_r = 1'b1;
        cmd(1'b1, CODE_LOOP_SCALE, SCALE_HALF, 2'b10, 16'h0000);
        cmd(1'b1, CODE_SETPOINT, 16'h0400, 2'b10, 16'h0000);
        tick(4);
        chk(vout, 16'h0400);
        chk(ref_code, exp_ref(16'h0400, SCALE_HALF));
        range_r = 1'b0;
        tick(4);
        chk(vout, 16'h0200);
        cmd(1'b0, CODE_LOOP_SCALE, 16'h0000, 2'b10, SCALE_HALF);
        cmd(1'b1, CODE_SETPOINT, 16'h0200, 2'b10, 16'h0000);
        cmd(1'b1, CODE_LOOP_SCALE, SCALE_ONE, 2'b10, 16'h0000);
        cmd(1'b1, CODE_SETPOINT, 16'h0123, 2'b10, 16'h0000);
        cmd(1'b1, CODE_STORE_ALL, 16'h0000, 2'b10, 16'h0000);
        chk(st_seen, 1'b1);
        chk(nvm_w, {16'h0123, SCALE_ONE});
        tick(1);
        chk(nvm_st, 1'b0);
        cmd(1'b1, CODE_SETPOINT, 16'h0200, 2'b10, 16'h0000);
        do_reset();
        cmd(1'b0, CODE_SETPOINT, 16'h0000, 2'b10, 16'h0123);
        chk(ref_code, 10'h123);
        cmd(1'b1, 8'h55, 16'h1234, 2'b01, 16'h0000);
        cmd(1'b1, CODE_SYNC_STATUS, 16'h1234, 2'b01, 16'h0000);
        cmd(1'b0, CODE_STORE_ALL, 16'h0000, 2'b01, 16'h0000);
        chk(st_seen, 1'b0);
        cmd(1'b0, CODE_SETPOINT, 16'h0000, 2'b10, 16'h0123);
        chk_per(200);
        sel = 1'b1;
        rkhz = 10'd1000;
        chk_per(100);
        cmd(1'b0, CODE_SYNC_STATUS, 16'h0000, 2'b10, 16'h0002);
        rkhz = 10'd200;
        chk_per(333);
        sel = 1'b0;
        rkhz = 10'd500;
        chk_per(200);
        sync_run = 1'b1;
        wait_lock(1'b1);
        chk_per(220);
        cmd(1'b0, CODE_SYNC_STATUS, 16'h0000, 2'b10, 16'h0001);
        @(posedge sync_clk);
        t0 = $realtime;
        chk_lag();
        sync_run = 1'b0;
        wait_lock(1'b0);
        chk(n <= 420, 1'b1);
        chk_per(200);
        slave = 1'b1;
        tick(4);
        sync_run = 1'b1;
        wait_lock(1'b1);
        @(negedge sync_clk);
        t0 = $realtime;
        chk_lag();
        cmd(1'b0, CODE_SYNC_STATUS, 16'h0000, 2'b10, 16'h0005);
        sync_run = 1'b0;
        wait_lock(1'b0);
        finish_test();
    end
endmodule : vout_setpoint_and_sync_control_tb_top
